/* File: sudc_map.svh */
// Register offsets, field positions and reset values of the scan up/down counter
`ifndef SUDC_MAP_SVH
`define SUDC_MAP_SVH
`define SUDC_OFF_COUNT 12'h000
`define SUDC_OFF_CTRL 12'h004
`define SUDC_OFF_RCOUNT 12'h008
`define SUDC_OFF_RCTRL 12'h00c
`define SUDC_OFF_PRESET 12'h010
`define SUDC_OFF_SCAN 12'h014
`define SUDC_OFF_IRQ_STAT 12'h018
`define SUDC_OFF_IRQ_MASK 12'h01c
`define SUDC_BIT_ZERO 0
`define SUDC_BIT_LT 1
`define SUDC_BIT_EQ 2
`define SUDC_BIT_GT 3
`define SUDC_BIT_INC 4
`define SUDC_BIT_DEC 5
`define SUDC_BIT_LOAD 6
`define SUDC_BIT_HINC 7
`define SUDC_BIT_HDEC 8
`define SUDC_BIT_HLOAD 9
`define SUDC_CTRL_WMASK 16'h0070
`define SUDC_RST_COUNT 16'h0000
`define SUDC_RST_CTRL 16'h0005
`define SUDC_RST_PRESET 16'h0000
`define SUDC_IRQ_BITS 4
`endif

/* File: sudc_pkg.sv */
// Types shared by the scan up/down counter
package sudc_pkg;
    typedef struct packed {
        logic [11:0] paddr;
        logic psel;
        logic penable;
        logic pwrite;
        logic [31:0] pwdata;
    } sudc_apb_req_t;
    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } sudc_apb_rsp_t;
    typedef struct packed {
        logic [15:0] count;
        logic [15:0] ctrl;
    } sudc_word_t;
    typedef enum logic [1:0] {
        SUDC_EV_WRAP_UP = 2'b00,
        SUDC_EV_WRAP_DN = 2'b01,
        SUDC_EV_LOAD = 2'b10,
        SUDC_EV_ZERO = 2'b11
    } sudc_event_t;
endpackage

/* File: sudc_scan_eval.sv */
// One scan evaluation of an up/down counter operand pair
`timescale 1ns/10ps
`default_nettype none
`include "sudc_map.svh"
module sudc_scan_eval
(
    input var sudc_pkg::sudc_word_t cur,
    input wire logic [15:0] preset,
    output var sudc_pkg::sudc_word_t nxt,
    output logic wrap_up,
    output logic wrap_dn,
    output logic load
);
    import sudc_pkg::*;
    logic inc_edge;
    logic dec_edge;
    logic [15:0] cnt;
    always_comb
    begin
        inc_edge = cur.ctrl[`SUDC_BIT_INC] & ~cur.ctrl[`SUDC_BIT_HINC];
        dec_edge = ~cur.ctrl[`SUDC_BIT_DEC] & cur.ctrl[`SUDC_BIT_HDEC];
        load = cur.ctrl[`SUDC_BIT_LOAD] & ~cur.ctrl[`SUDC_BIT_HLOAD];
        cnt = cur.count;
        if (inc_edge)
        begin
            cnt = cnt + 16'h0001;
        end
        if (dec_edge)
        begin
            cnt = cnt - 16'h0001;
        end
        if (load)
        begin
            cnt = preset;
        end
        wrap_up = inc_edge & ~dec_edge & (cur.count == 16'hffff);
        wrap_dn = dec_edge & ~inc_edge & (cur.count == 16'h0000);
        nxt.count = cnt;
        nxt.ctrl = cur.ctrl;
        nxt.ctrl[`SUDC_BIT_ZERO] = (cnt == 16'h0000);
        nxt.ctrl[`SUDC_BIT_LT] = (cnt < preset);
        nxt.ctrl[`SUDC_BIT_EQ] = (cnt == preset);
        nxt.ctrl[`SUDC_BIT_GT] = (cnt > preset);
        nxt.ctrl[`SUDC_BIT_HINC] = cur.ctrl[`SUDC_BIT_INC];
        nxt.ctrl[`SUDC_BIT_HDEC] = cur.ctrl[`SUDC_BIT_DEC];
        nxt.ctrl[`SUDC_BIT_HLOAD] = cur.ctrl[`SUDC_BIT_LOAD];
        nxt.ctrl[15:10] = 6'h00;
    end
endmodule
`default_nettype wire

/* File: sudc_top.sv */
// Scan up/down counter with retentive copy, APB registers and interrupt
// Functional notes
// - Rising increment bit adds one
// - Up count wraps 65535 to 0
// - Falling decrement bit subtracts one
// - Down count wraps 0 to 65535
// - Rising load bit copies preset
// - Zero flag tracks count equal zero
// - Less flag tracks count below preset
// - Equal flag tracks count equal preset
// - Greater flag tracks count above preset
// - Control bits saved to history each scan
// - Retentive copy identical, survives power loss
//
// Decided for this implementation: the APB register port and the register addresses.
`timescale 1ns/10ps
`default_nettype none
`include "sudc_map.svh"
module sudc_top
(
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic [11:0] PADDR,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    output logic IRQ
);
    import sudc_pkg::*;
    sudc_apb_req_t req;
    sudc_word_t vol_reg;
    sudc_word_t ret_reg;
    sudc_word_t vol_next;
    sudc_word_t ret_next;
    logic [15:0] preset_reg;
    logic [3:0] irq_stat_reg;
    logic [3:0] irq_mask_reg;
    logic [3:0] ev_vol;
    logic [3:0] ev_ret;
    logic scan_tick;
    logic wr_acc;
    logic rd_acc;
    logic hit;
    logic [31:0] rd_data;
    logic v_wu;
    logic v_wd;
    logic v_ld;
    logic r_wu;
    logic r_wd;
    logic r_ld;

    function automatic logic [15:0] ctrl_write(input logic [15:0] old, input logic [15:0] wd);
        ctrl_write = (old & ~`SUDC_CTRL_WMASK) | (wd & `SUDC_CTRL_WMASK);
    endfunction

    function automatic logic [3:0] events_of(input logic wu, input logic wd,
                                             input logic ld, input logic zero_new,
                                             input logic zero_old);
        events_of = 4'h0;
        events_of[SUDC_EV_WRAP_UP] = wu;
        events_of[SUDC_EV_WRAP_DN] = wd;
        events_of[SUDC_EV_LOAD] = ld;
        events_of[SUDC_EV_ZERO] = zero_new & ~zero_old;
    endfunction

    always_comb
    begin
        req.paddr = PADDR;
        req.psel = PSEL;
        req.penable = PENABLE;
        req.pwrite = PWRITE;
        req.pwdata = PWDATA;
    end

    // Writes commit only on the edge that sees ready high
    assign wr_acc = req.psel & req.penable & req.pwrite & PREADY;
    assign rd_acc = req.psel & req.penable & ~req.pwrite & ~PREADY;
    // One scan per write to the scan register with bit 0 set; software owns the scan rate
    assign scan_tick = wr_acc & (req.paddr == `SUDC_OFF_SCAN) & req.pwdata[0];

    sudc_scan_eval u_vol
    (
        .cur(vol_reg),
        .preset(preset_reg),
        .nxt(vol_next),
        .wrap_up(v_wu),
        .wrap_dn(v_wd),
        .load(v_ld)
    );

    sudc_scan_eval u_ret
    (
        .cur(ret_reg),
        .preset(preset_reg),
        .nxt(ret_next),
        .wrap_up(r_wu),
        .wrap_dn(r_wd),
        .load(r_ld)
    );

    // Zero event follows the count itself; stored flag is stale after a count write
    assign ev_vol = events_of(v_wu, v_wd, v_ld, vol_next.ctrl[0], vol_reg.count == 16'h0000);
    assign ev_ret = events_of(r_wu, r_wd, r_ld, ret_next.ctrl[0], ret_reg.count == 16'h0000);

    // Volatile operand pair, set to count 0 and ctrl 0x0005 by power-on reset
    always_ff @(posedge CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            vol_reg.count <= `SUDC_RST_COUNT;
            vol_reg.ctrl <= `SUDC_RST_CTRL;
        end
        else if (scan_tick)
        begin
            vol_reg <= vol_next;
        end
        else if (wr_acc && req.paddr == `SUDC_OFF_COUNT)
        begin
            vol_reg.count <= req.pwdata[15:0];
        end
        else if (wr_acc && req.paddr == `SUDC_OFF_CTRL)
        begin
            vol_reg.ctrl <= ctrl_write(vol_reg.ctrl, req.pwdata[15:0]);
        end
    end

    // Retentive pair has no reset: it models storage kept across power loss
    always_ff @(posedge CLK)
    begin
        if (scan_tick)
        begin
            ret_reg <= ret_next;
        end
        else if (wr_acc && req.paddr == `SUDC_OFF_RCOUNT)
        begin
            ret_reg.count <= req.pwdata[15:0];
        end
        else if (wr_acc && req.paddr == `SUDC_OFF_RCTRL)
        begin
            ret_reg.ctrl <= ctrl_write(ret_reg.ctrl, req.pwdata[15:0]);
        end
    end

    always_ff @(posedge CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            preset_reg <= `SUDC_RST_PRESET;
        end
        else if (wr_acc && req.paddr == `SUDC_OFF_PRESET)
        begin
            preset_reg <= req.pwdata[15:0];
        end
    end

    // Set wins over a simultaneous write-one clear
    always_ff @(posedge CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            irq_stat_reg <= 4'h0;
        end
        else
        begin
            if (wr_acc && req.paddr == `SUDC_OFF_IRQ_STAT)
            begin
                irq_stat_reg <= (irq_stat_reg & ~req.pwdata[3:0])
                    | (scan_tick ? (ev_vol | ev_ret) : 4'h0);
            end
            else if (scan_tick)
            begin
                irq_stat_reg <= irq_stat_reg | ev_vol | ev_ret;
            end
        end
    end

    always_ff @(posedge CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            irq_mask_reg <= 4'h0;
        end
        else if (wr_acc && req.paddr == `SUDC_OFF_IRQ_MASK)
        begin
            irq_mask_reg <= req.pwdata[3:0];
        end
    end

    // Stat is set at the scan edge and IRQ follows the stored stat one edge later; one cycle lag accepted
    always_ff @(posedge CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            IRQ <= 1'b0;
        end
        else
        begin
            IRQ <= |(irq_stat_reg & irq_mask_reg);
        end
    end

    always_comb
    begin
        hit = 1'b1;
        rd_data = 32'h0000_0000;
        if (req.paddr == `SUDC_OFF_COUNT)
        begin
            rd_data = {16'h0000, vol_reg.count};
        end
        else if (req.paddr == `SUDC_OFF_CTRL)
        begin
            rd_data = {16'h0000, vol_reg.ctrl};
        end
        else if (req.paddr == `SUDC_OFF_RCOUNT)
        begin
            rd_data = {16'h0000, ret_reg.count};
        end
        else if (req.paddr == `SUDC_OFF_RCTRL)
        begin
            rd_data = {16'h0000, ret_reg.ctrl};
        end
        else if (req.paddr == `SUDC_OFF_PRESET)
        begin
            rd_data = {16'h0000, preset_reg};
        end
        else if (req.paddr == `SUDC_OFF_SCAN)
        begin
            rd_data = 32'h0000_0000;
        end
        else if (req.paddr == `SUDC_OFF_IRQ_STAT)
        begin
            rd_data = {28'h0000000, irq_stat_reg};
        end
        else if (req.paddr == `SUDC_OFF_IRQ_MASK)
        begin
            rd_data = {28'h0000000, irq_mask_reg};
        end
        else
        begin
            hit = 1'b0;
        end
    end

    // Answer one cycle into the access phase
    always_ff @(posedge CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            PREADY <= 1'b0;
            PRDATA <= 32'h0000_0000;
            PSLVERR <= 1'b0;
        end
        else
        begin
            PREADY <= req.psel & req.penable & ~PREADY;
            PSLVERR <= req.psel & req.penable & ~PREADY & ~hit;
            if (rd_acc)
            begin
                PRDATA <= rd_data;
            end
        end
    end
endmodule
`default_nettype wire

/* File: sudc_top_checker.sv */
// Port-level assertions for the scan up/down counter
`timescale 1ns/10ps
`default_nettype none
`include "sudc_map.svh"
module sudc_top_checker
(
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic [11:0] PADDR,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [31:0] PWDATA,
    input wire logic [31:0] PRDATA,
    input wire logic PREADY,
    input wire logic PSLVERR,
    input wire logic IRQ
);
    logic ctrl_sel;
    assign ctrl_sel = (PADDR == `SUDC_OFF_CTRL) || (PADDR == `SUDC_OFF_RCTRL);
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!RST_N);
    sequence s_take;
        PSEL && PENABLE && !PREADY;
    endsequence
    sequence s_rd_done;
        PREADY && !PWRITE && !PSLVERR;
    endsequence
    property p_answer;
        s_take |=> PREADY;
    endproperty
    property p_pulse;
        PREADY |=> !PREADY;
    endproperty
    property p_err_ready;
        PSLVERR |-> PREADY;
    endproperty
    property p_err_zero;
        PSLVERR && !PWRITE |-> PRDATA == 32'h0;
    endproperty
    // Master holds the address through the answer cycle
    property p_mapped_ok;
        PREADY && PADDR[1:0] == 2'b00 && PADDR <= `SUDC_OFF_IRQ_MASK |-> !PSLVERR;
    endproperty
    property p_rel_onehot;
        s_rd_done ##0 ctrl_sel |-> $onehot(PRDATA[3:1]);
    endproperty
    property p_zero_not_gt;
        s_rd_done ##0 (ctrl_sel && PRDATA[0]) |-> !PRDATA[3];
    endproperty
    property p_ctrl_upper;
        s_rd_done ##0 ctrl_sel |-> PRDATA[31:10] == 22'h0;
    endproperty
    // Mask commits on the ready edge, the registered output follows one edge later
    property p_irq_off;
        PSEL && PENABLE && PREADY && PWRITE && PADDR == `SUDC_OFF_IRQ_MASK
            && PWDATA[3:0] == 4'h0 |=> ##1 !IRQ;
    endproperty
    a_answer: assert property (p_answer) else $error("no answer after access");
    a_pulse: assert property (p_pulse) else $error("ready longer than one cycle");
    a_err_ready: assert property (p_err_ready) else $error("error without ready");
    a_err_zero: assert property (p_err_zero) else $error("refused read not zero");
    a_mapped_ok: assert property (p_mapped_ok) else $error("mapped access refused");
    a_rel_onehot: assert property (p_rel_onehot)
        else $error("compare flags not one-hot");
    a_zero_not_gt: assert property (p_zero_not_gt)
        else $error("zero count above preset");
    a_ctrl_upper: assert property (p_ctrl_upper) else $error("control upper bits set");
    a_irq_off: assert property (p_irq_off) else $error("irq high with all masked");
endmodule
bind sudc_top sudc_top_checker u_chk (.CLK, .RST_N, .PADDR, .PSEL, .PENABLE, .PWRITE,
    .PWDATA, .PRDATA, .PREADY, .PSLVERR, .IRQ);
`default_nettype wire

/* File: scan_updown_counter_test.sv */
// Self-checking bench for the scan up/down counter
`timescale 1ns/10ps
`default_nettype none
`include "sudc_map.svh"
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin n_fail++; \
    $display("unexpected %s exp %h got %h", nm, e, g); end end
module scan_updown_counter_test;
    logic CLK = 1'b0;
    logic RST_N = 1'b0;
    logic [11:0] PADDR = 12'h000;
    logic PSEL = 1'b0;
    logic PENABLE = 1'b0;
    logic PWRITE = 1'b0;
    logic [31:0] PWDATA = 32'h0;
    logic [31:0] PRDATA;
    logic PREADY;
    logic PSLVERR;
    logic IRQ;
    logic [31:0] rd;
    logic er;
    int n_fail = 0;
    int checked = 0;
    always #5 CLK = ~CLK;
    sudc_top DUT (.CLK, .RST_N, .PADDR, .PSEL, .PENABLE, .PWRITE, .PWDATA, .PRDATA,
        .PREADY, .PSLVERR, .IRQ);
    task automatic finish_test();
        $display("checks %0d mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // Ready, read data and error are taken at the edge that sees ready high
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge CLK);
        PSEL <= 1'b1;
        PENABLE <= 1'b0;
        PWRITE <= w;
        PADDR <= a;
        PWDATA <= d;
        @(posedge CLK);
        PENABLE <= 1'b1;
        do
        begin
            @(posedge CLK);
            n++;
        end
        while (PREADY !== 1'b1 && n < 20);
        if (n >= 20)
        begin
            n_fail++;
            finish_test();
        end
        rd = PRDATA;
        er = PSLVERR;
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
    endtask
    task automatic rchk(input logic [11:0] a, input logic [31:0] e, input string nm);
        apb(1'b0, a, 32'h0);
        `CHK(nm, e, rd)
    endtask
    task automatic scan();
        apb(1'b1, `SUDC_OFF_SCAN, 32'h1);
    endtask
    task automatic run_copy(input logic [11:0] c, input logic [11:0] s, input string nm);
        apb(1'b1, `SUDC_OFF_IRQ_STAT, 32'hf);
        apb(1'b1, c, 32'hffff);
        apb(1'b1, s, 32'h10);
        scan();
        rchk(c, 32'h0, "up wrap");
        rchk(s, 32'h93, "up flags");
        rchk(`SUDC_OFF_IRQ_STAT, 32'h9, "events");
        @(negedge CLK);
        `CHK("irq masked", 1'b0, IRQ)
        apb(1'b1, `SUDC_OFF_IRQ_MASK, 32'h1);
        repeat (2) @(negedge CLK);
        `CHK("irq raised", 1'b1, IRQ)
        apb(1'b1, `SUDC_OFF_IRQ_STAT, 32'hf);
        repeat (2) @(negedge CLK);
        `CHK("irq cleared", 1'b0, IRQ)
        apb(1'b1, `SUDC_OFF_IRQ_MASK, 32'h0);
        scan();
        rchk(c, 32'h0, "held inc");
        apb(1'b1, s, 32'h20);
        scan();
        rchk(c, 32'h0, "rising dec");
        apb(1'b1, s, 32'h0);
        scan();
        rchk(c, 32'hffff, "down wrap");
        rchk(s, 32'h8, "down flags");
        rchk(`SUDC_OFF_IRQ_STAT, 32'h2, "down event");
        apb(1'b1, s, 32'h50);
        scan();
        rchk(c, 32'h5, "load wins");
        rchk(s, 32'h2d4, "load flags");
        $display("test %s done", nm);
    endtask
    initial
    begin
        repeat (10) @(posedge CLK);
        RST_N <= 1'b1;
        rchk(`SUDC_OFF_COUNT, 32'h0, "count reset");
        rchk(`SUDC_OFF_CTRL, 32'h5, "ctrl reset");
        rchk(`SUDC_OFF_PRESET, 32'h0, "preset reset");
        rchk(`SUDC_OFF_IRQ_STAT, 32'h0, "stat reset");
        rchk(`SUDC_OFF_IRQ_MASK, 32'h0, "mask reset");
        rchk(12'h020, 32'h0, "unmapped read");
        `CHK("unmapped error", 1'b1, er)
        $display("test reset done");
        // Retained copy powers up unknown, so settle its history first
        apb(1'b1, `SUDC_OFF_PRESET, 32'h5);
        apb(1'b1, `SUDC_OFF_RCTRL, 32'h0);
        scan();
        scan();
        apb(1'b1, `SUDC_OFF_RCOUNT, 32'h0);
        run_copy(`SUDC_OFF_COUNT, `SUDC_OFF_CTRL, "volatile");
        run_copy(`SUDC_OFF_RCOUNT, `SUDC_OFF_RCTRL, "retentive");
        RST_N <= 1'b0;
        repeat (10) @(posedge CLK);
        RST_N <= 1'b1;
        rchk(`SUDC_OFF_RCOUNT, 32'h5, "kept count");
        rchk(`SUDC_OFF_RCTRL, 32'h2d4, "kept flags");
        rchk(`SUDC_OFF_COUNT, 32'h0, "lost count");
        rchk(`SUDC_OFF_CTRL, 32'h5, "lost flags");
        $display("test power cycle done");
        finish_test();
    end
endmodule
`default_nettype wire
